// [verilog/io_space_pkg.sv]
// shared constants for the i/o space access decoder
// assumes a single 100 MHz system clock and an 8-bit data path
package io_space_pkg;
   // ************************************
   // address map
   // ************************************
   localparam logic [15:0] IoShortLast = 16'h003f;
   localparam logic [15:0] IoBitLast = 16'h001f;
   localparam logic [15:0] IoDataOffset = 16'h0020;
   localparam logic [15:0] ExtFirst = 16'h0060;
   localparam logic [15:0] ExtLast = 16'h00ff;
   localparam int IoShortCount = 64;
   localparam int ExtCount = 160;
   localparam int RegCount = 224;
   localparam int WorkRegCount = 32;
   // ************************************
   // reset values and access kinds
   // ************************************
   localparam logic [7:0] RegResetValue = 8'h00;
   typedef enum logic [2:0] {
      ACC_NONE = 3'b000,
      ACC_IO_READ = 3'b001,
      ACC_IO_WRITE = 3'b010,
      ACC_BIT_SET = 3'b011,
      ACC_BIT_CLEAR = 3'b100,
      ACC_BIT_TEST = 3'b101,
      ACC_MEM_READ = 3'b110,
      ACC_MEM_WRITE = 3'b111
   } acc_type;
endpackage

// [verilog/io_slot.sv]
// one peripheral register slot with per-bit write-one-to-clear option
// assumes hardware set pulses come from the owning peripheral
`timescale 1ns/1ps
module io_slot #(
   parameter logic [7:0] W1C_MASK = 8'h00
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // write side
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic [7:0] hwSet,
   // state
   output logic [7:0] value
);
   logic [7:0] val_ff;
   wire logic [7:0] nxt_val;
   wire logic [7:0] plainNext;
   wire logic [7:0] clrNext;
   // w1c bits drop where a one is written, zero leaves them; hw set wins
   assign plainNext = wrEn ? wrData : val_ff;
   assign clrNext = wrEn ? (val_ff & ~wrData) : val_ff;
   assign nxt_val = ((plainNext & ~W1C_MASK) | (clrNext & W1C_MASK)) | (hwSet & W1C_MASK);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         val_ff <= io_space_pkg::RegResetValue;
      end else begin
         val_ff <= nxt_val;
      end
   end
   assign value = val_ff;
endmodule // io_slot

// [verilog/io_space_access_decoder.sv]
// decoder between the cpu core and the peripheral register space
// assumes one access per cycle from the core, inputs synchronous to ref_clk
//
// Operation
// - bit set, clear and test only work on i/o addresses 0x00 to 0x1f
// - dedicated i/o read and write use short addresses 0x00 to 0x3f
// - data-space address of a short i/o register is short address plus 0x20
// - dedicated i/o opcode field reaches only 64 locations
// - extended region 0x60 to 0xff only reachable by data-space accesses
// - every i/o location reachable by data-space load and store
// - legacy mode unmaps extended region, it becomes plain data memory
// - status flags clear on written one, zero leaves them unchanged
// - bit set and clear rewrite the whole register, clearing every set flag but the one a bit clear addresses
`timescale 1ns/1ps
module io_space_access_decoder #(
   parameter logic [7:0] IMPL_COUNT = 8'd224,
   parameter logic [7:0] W1C_MASK = 8'h0f
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // mode
   input wire logic legacyMode,
   // core request
   input wire logic [2:0] accKind,
   input wire logic [15:0] accAddr,
   input wire logic [2:0] bitSel,
   input wire logic [7:0] wrData,
   // peripheral flag set pulses, per register
   input wire logic [io_space_pkg::RegCount*8-1:0] hwSetFlags,
   // answers
   output logic [7:0] rdData,
   output logic rdValid,
   output logic bitTrue,
   output logic sramSel,
   output logic accError
);
   // ************************************
   // address decode
   // ************************************
   wire logic isIo = accKind inside {io_space_pkg::ACC_IO_READ, io_space_pkg::ACC_IO_WRITE};
   wire logic isBit = accKind inside {io_space_pkg::ACC_BIT_SET, io_space_pkg::ACC_BIT_CLEAR,
                                      io_space_pkg::ACC_BIT_TEST};
   wire logic isMem = accKind inside {io_space_pkg::ACC_MEM_READ, io_space_pkg::ACC_MEM_WRITE};
   // short i/o and bit forms carry only six/five address bits of opcode
   wire logic ioInRange = accAddr <= io_space_pkg::IoShortLast;
   wire logic bitInRange = accAddr <= io_space_pkg::IoBitLast;
   wire logic [15:0] memIdx16 = accAddr - io_space_pkg::IoDataOffset;
   wire logic memLow = accAddr >= io_space_pkg::IoDataOffset && accAddr < io_space_pkg::ExtFirst;
   wire logic memExt = accAddr >= io_space_pkg::ExtFirst && accAddr <= io_space_pkg::ExtLast;
   // legacy mode hands the extended window to sram
   wire logic memHit = isMem && (memLow || (memExt && !legacyMode));
   wire logic ioHit = (isIo && ioInRange) || (isBit && bitInRange);
   wire logic [7:0] regIdx = isMem ? memIdx16[7:0] : accAddr[7:0];
   wire logic implHit = (ioHit || memHit) && regIdx < IMPL_COUNT;
   wire logic toSram = isMem && memExt && legacyMode;
   wire logic badAcc = (accKind != io_space_pkg::ACC_NONE) && !implHit && !toSram;
   // ************************************
   // register array
   // ************************************
   logic [7:0] regVal [io_space_pkg::RegCount];
   wire logic [7:0] curVal = implHit ? regVal[regIdx] : 8'h00;
   wire logic [7:0] bitMask = 8'h01 << bitSel;
   // rmw writes the whole byte back, so set w1c flags other than a bit clear's own bit see a one and clear
   wire logic [7:0] rmwSet = curVal | bitMask;
   wire logic [7:0] rmwClr = curVal & ~bitMask;
   wire logic isWrite = accKind inside {io_space_pkg::ACC_IO_WRITE, io_space_pkg::ACC_MEM_WRITE,
                                        io_space_pkg::ACC_BIT_SET, io_space_pkg::ACC_BIT_CLEAR};
   wire logic [7:0] slotData = (accKind == io_space_pkg::ACC_BIT_SET) ? rmwSet :
                               (accKind == io_space_pkg::ACC_BIT_CLEAR) ? rmwClr : wrData;
   wire logic doWrite = isWrite && implHit;
   wire logic isRead = accKind inside {io_space_pkg::ACC_IO_READ, io_space_pkg::ACC_MEM_READ};
   genvar g;
   generate
      for (g = 0; g < io_space_pkg::RegCount; g++) begin : gSlot
         io_slot #(
            .W1C_MASK(W1C_MASK)
         ) uSlot (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .wrEn(doWrite && regIdx == 8'(g)),
            .wrData(slotData),
            .hwSet(hwSetFlags[g*8 +: 8]),
            .value(regVal[g])
         );
      end
   endgenerate
   // ************************************
   // answer registers
   // ************************************
   logic [7:0] rdData_ff;
   logic rdValid_ff;
   logic bitTrue_ff;
   logic sramSel_ff;
   logic accError_ff;
   wire logic [7:0] nxt_rdData = (isRead && implHit) ? curVal : 8'h00;
   wire logic nxt_bitTrue = (accKind == io_space_pkg::ACC_BIT_TEST) && implHit && curVal[bitSel];
   // registered answers, one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdData_ff <= 8'h00;
         rdValid_ff <= 1'b0;
         bitTrue_ff <= 1'b0;
         sramSel_ff <= 1'b0;
         accError_ff <= 1'b0;
      end else begin
         rdData_ff <= nxt_rdData;
         rdValid_ff <= isRead && implHit;
         bitTrue_ff <= nxt_bitTrue;
         sramSel_ff <= toSram;
         accError_ff <= badAcc;
      end
   end
   assign rdData = rdData_ff;
   assign rdValid = rdValid_ff;
   assign bitTrue = bitTrue_ff;
   assign sramSel = sramSel_ff;
   assign accError = accError_ff;
   // ************************************
   // checks
   // ************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence extIoAcc;
      isIo && accAddr > io_space_pkg::IoShortLast;
   endsequence
   bit_range_a: assert property (isBit && !bitInRange |=> !bitTrue) else $error("bit access out of range");
   io_range_a: assert property (extIoAcc |=> accError && !rdValid) else $error("io beyond 0x3f taken");
   io_short_a: assert property (isIo |-> !(accAddr > io_space_pkg::IoShortLast && implHit))
      else $error("io hit past 64");
   mem_offset_a: assert property (isMem && memLow |-> regIdx == accAddr[7:0] - 8'h20)
      else $error("data offset wrong");
   ext_legacy_a: assert property (isMem && memExt && legacyMode |=> sramSel && !rdValid)
      else $error("legacy ext not sram");
   ext_mem_a: assert property (isMem && memExt && !legacyMode && accKind == io_space_pkg::ACC_MEM_READ && implHit
      |=> rdValid && !accError) else $error("ext read lost");
   mem_read_a: assert property (accKind == io_space_pkg::ACC_MEM_READ && memLow
      |=> rdData == $past(curVal)) else $error("data read mismatch");
   unimpl_zero_a: assert property (isRead && !implHit |=> rdData == 8'h00) else $error("unmapped read nonzero");
   w1c_clear_a: assert property (accKind == io_space_pkg::ACC_IO_WRITE && implHit && hwSetFlags[regIdx*8 +: 8] == 8'h00
      |=> (regVal[$past(regIdx)] & W1C_MASK) == ($past(curVal) & ~$past(wrData) & W1C_MASK))
      else $error("w1c wrong");
   rmw_clear_a: assert property (accKind == io_space_pkg::ACC_BIT_SET && implHit
      && hwSetFlags[regIdx*8 +: 8] == 8'h00
      |=> (regVal[$past(regIdx)] & W1C_MASK) == 8'h00) else $error("rmw left flag");
   // ************************************
   // answer shape and write-back checks
   // ************************************
   // an answer carries one meaning only, so a refused access shows nothing else
   sequence refusedAcc;
      badAcc;
   endsequence
   sequence quietAnswer;
      !rdValid && !bitTrue && !sramSel && rdData == 8'h00;
   endsequence
   sequence plainWrite;
      accKind inside {io_space_pkg::ACC_IO_WRITE, io_space_pkg::ACC_MEM_WRITE} && implHit;
   endsequence
   sequence noHwSet;
      hwSetFlags[regIdx*8 +: 8] == 8'h00;
   endsequence
   // refused accesses raise the error pulse and leave every other answer low
   refuse_quiet_a: assert property (refusedAcc |=> accError ##0 quietAnswer)
      else $error("refused access answered");
   // an idle cycle must not leave a stale pulse behind
   idle_quiet_a: assert property (accKind == io_space_pkg::ACC_NONE |=> !accError ##0 quietAnswer)
      else $error("answer without request");
   // plain bits take the written byte, whichever path wrote it
   plain_write_a: assert property (plainWrite ##0 noHwSet
      |=> (regVal[$past(regIdx)] & ~W1C_MASK) == ($past(wrData) & ~W1C_MASK))
      else $error("plain bits not written");
   // extended window writes land in their slot while not in legacy mode
   ext_write_a: assert property (accKind == io_space_pkg::ACC_MEM_WRITE && memExt && !legacyMode && implHit
      |=> !accError && !sramSel)
      else $error("ext write refused");
   // legacy mode must not touch the slot behind the extended address
   legacy_keep_a: assert property (accKind == io_space_pkg::ACC_MEM_WRITE && toSram ##0 noHwSet
      |=> regVal[$past(regIdx)] == $past(regVal[regIdx]))
      else $error("legacy write stored");
   // bit set raises its own bit when that bit is a plain one
   bit_set_a: assert property (accKind == io_space_pkg::ACC_BIT_SET && implHit && !W1C_MASK[bitSel]
      |=> regVal[$past(regIdx)][$past(bitSel)])
      else $error("bit set lost");
   // bit clear drops its own bit when that bit is a plain one
   bit_clr_a: assert property (accKind == io_space_pkg::ACC_BIT_CLEAR && implHit && !W1C_MASK[bitSel]
      |=> !regVal[$past(regIdx)][$past(bitSel)])
      else $error("bit clear lost");
   // clearing one bit still writes ones back over every other set flag
   rmw_bitclr_a: assert property (accKind == io_space_pkg::ACC_BIT_CLEAR && implHit ##0 noHwSet
      |=> (regVal[$past(regIdx)] & W1C_MASK & ~$past(bitMask)) == 8'h00)
      else $error("rmw clear left flag");
   // a bit test answers with the addressed bit as it stood when taken
   bit_test_a: assert property (accKind == io_space_pkg::ACC_BIT_TEST && implHit
      |=> bitTrue == $past(curVal[bitSel]))
      else $error("bit test wrong");
   // bit forms never read or pass anything to sram
   bit_quiet_a: assert property (isBit |=> !rdValid && !sramSel && rdData == 8'h00)
      else $error("bit form answered as read");
   // a hardware set in the same cycle as a clearing write must win
   set_wins_a: assert property (plainWrite ##0 (hwSetFlags[regIdx*8 +: 8] != 8'h00)
      |=> (regVal[$past(regIdx)] & $past(hwSetFlags[regIdx*8 +: 8]) & W1C_MASK)
      == ($past(hwSetFlags[regIdx*8 +: 8]) & W1C_MASK))
      else $error("clear beat hw set");
   // legacy mode leaves short i/o through data space untouched
   legacy_low_a: assert property (accKind == io_space_pkg::ACC_MEM_READ && memLow && legacyMode && implHit
      |=> rdValid && !sramSel)
      else $error("legacy low read lost");
   // short reads answer only with the registered byte of that slot
   io_read_a: assert property (accKind == io_space_pkg::ACC_IO_READ && implHit
      |=> rdValid && !accError && rdData == $past(curVal))
      else $error("io read lost");
   // bit forms above the bit range raise the error pulse
   bit_refuse_a: assert property (isBit && !bitInRange |=> accError)
      else $error("bit form past 0x1f taken");
   // the data-space error pulse covers everything outside both windows
   mem_refuse_a: assert property (isMem && !memLow && !memExt |=> accError && !sramSel)
      else $error("stray data access taken");
   // the error pulse and a good read never come together
   err_excl_a: assert property (accError |-> !rdValid && !bitTrue && !sramSel)
      else $error("error with answer");
endmodule // io_space_access_decoder

// [verification/core_model.sv]
// core model issuing i/o and data-space requests
// assumes the decoder answers in the cycle after the taking edge
`timescale 1ns/1ps
module core_model (
   // clock
   input wire logic ref_clk,
   // answers
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic bitTrue,
   input wire logic sramSel,
   input wire logic accError,
   // requests
   output logic [2:0] accKind,
   output logic [15:0] accAddr,
   output logic [2:0] bitSel,
   output logic [7:0] wrData
);
   initial begin
      accKind = 3'h0;
      accAddr = 16'h0000;
      bitSel = 3'h0;
      wrData = 8'h00;
   end
   // one request held over one edge; address and data lines flip so stale values never match
   task automatic op(input logic [2:0] k, input logic [15:0] a, input logic [2:0] b, input logic [7:0] d,
         output logic [11:0] ans);
      @(negedge ref_clk);
      accKind = k;
      accAddr = a;
      bitSel = b;
      wrData = d;
      @(negedge ref_clk);
      ans = {accError, sramSel, bitTrue, rdValid, rdData};
      accKind = 3'h0;
      accAddr = ~a;
      wrData = ~d;
   endtask
endmodule // core_model

// [verification/tb_io_space_access_decoder.sv]
// self-checking bench for the i/o space access decoder
// assumes core_model drives the request side
`timescale 1ns/1ps
module tb_io_space_access_decoder;
   logic ref_clk, rst_n, legacyMode, rdValid, bitTrue, sramSel, accError;
   logic [io_space_pkg::RegCount*8-1:0] hwSetFlags;
   logic [2:0] accKind, bitSel;
   logic [15:0] accAddr;
   logic [7:0] wrData, rdData;
   int bad_count = 0;
   int checks_done = 0;
   // fewer implemented slots so the top of the map is unmapped
   io_space_access_decoder #(.IMPL_COUNT(8'd200)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .legacyMode(legacyMode),
      .accKind(accKind), .accAddr(accAddr), .bitSel(bitSel), .wrData(wrData), .hwSetFlags(hwSetFlags),
      .rdData(rdData), .rdValid(rdValid), .bitTrue(bitTrue), .sramSel(sramSel), .accError(accError));
   core_model core (.ref_clk(ref_clk), .rdData(rdData), .rdValid(rdValid), .bitTrue(bitTrue), .sramSel(sramSel),
      .accError(accError), .accKind(accKind), .accAddr(accAddr), .bitSel(bitSel), .wrData(wrData));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // answer packs error, sram, bit, valid and data
   task automatic xfer(input logic [2:0] k, input logic [15:0] a, input logic [2:0] b, input logic [7:0] d,
         input logic [11:0] exp, input string what);
      logic [11:0] ans;
      core.op(k, a, b, d, ans);
      check(what, ans, exp);
   endtask
   task automatic io_paths;
      xfer(io_space_pkg::ACC_IO_WRITE, 16'h003f, 3'h0, 8'ha0, 12'h000, "io wr top");
      xfer(io_space_pkg::ACC_MEM_READ, 16'h005f, 3'h0, 8'h00, 12'h1a0, "mem rd io top");
      xfer(io_space_pkg::ACC_MEM_WRITE, 16'h0025, 3'h0, 8'hc0, 12'h000, "mem wr io");
      xfer(io_space_pkg::ACC_IO_READ, 16'h0005, 3'h0, 8'h00, 12'h1c0, "io rd");
      xfer(io_space_pkg::ACC_IO_READ, 16'h0040, 3'h0, 8'h00, 12'h800, "io rd 0x40");
      xfer(io_space_pkg::ACC_MEM_WRITE, 16'h0060, 3'h0, 8'h50, 12'h000, "ext wr");
      xfer(io_space_pkg::ACC_MEM_READ, 16'h0060, 3'h0, 8'h00, 12'h150, "ext rd");
   endtask
   // low nibble is write-one-to-clear by default
   task automatic bit_ops;
      xfer(io_space_pkg::ACC_IO_WRITE, 16'h0003, 3'h0, 8'hf0, 12'h000, "flag wr");
      hwSetFlags[3*8+:8] = 8'h03;
      @(negedge ref_clk);
      hwSetFlags = '0;
      xfer(io_space_pkg::ACC_IO_READ, 16'h0003, 3'h0, 8'h00, 12'h1f3, "flags set");
      xfer(io_space_pkg::ACC_IO_WRITE, 16'h0003, 3'h0, 8'h01, 12'h000, "flag clr");
      xfer(io_space_pkg::ACC_IO_READ, 16'h0003, 3'h0, 8'h00, 12'h102, "one clears");
      xfer(io_space_pkg::ACC_BIT_SET, 16'h0003, 3'h7, 8'h00, 12'h000, "bit set");
      xfer(io_space_pkg::ACC_IO_READ, 16'h0003, 3'h0, 8'h00, 12'h180, "rmw clears");
      xfer(io_space_pkg::ACC_BIT_TEST, 16'h0003, 3'h7, 8'h00, 12'h200, "test set");
      xfer(io_space_pkg::ACC_BIT_CLEAR, 16'h0003, 3'h7, 8'h00, 12'h000, "bit clr");
      xfer(io_space_pkg::ACC_BIT_TEST, 16'h0003, 3'h7, 8'h00, 12'h000, "test clr");
      xfer(io_space_pkg::ACC_BIT_SET, 16'h0020, 3'h0, 8'h00, 12'h800, "bit 0x20");
      xfer(io_space_pkg::ACC_BIT_TEST, 16'h0021, 3'h0, 8'h00, 12'h800, "test 0x21");
   endtask
   task automatic modes;
      legacyMode = 1'b1;
      xfer(io_space_pkg::ACC_MEM_READ, 16'h0080, 3'h0, 8'h00, 12'h400, "legacy ext");
      legacyMode = 1'b0;
      xfer(io_space_pkg::ACC_MEM_WRITE, 16'h00f0, 3'h0, 8'h50, 12'h800, "unmapped wr");
      xfer(io_space_pkg::ACC_MEM_READ, 16'h00f0, 3'h0, 8'h00, 12'h800, "unmapped rd");
   endtask
   // reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      legacyMode = 1'b0;
      hwSetFlags = '0;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      io_paths;
      bit_ops;
      modes;
      wrap_up;
   end
   // run needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      wrap_up;
   end
endmodule // tb_io_space_access_decoder
